//--- bench/sww_host_model.sv
`timescale 1ns/1ps
module sww_host_model (
    input  wire logic clk,          // system clock
    input  wire logic dev_pull,     // device pulls the reset line low
    input  wire logic switch_press, // manual reset switch closed
    output logic      line_level,   // resolved reset line level
    output int        host_resets   // reset entries seen by the host
);
    logic line_q;

    // ************************************************************
    // wired line: weak pull-up only wins when nobody pulls low
    // ************************************************************
    assign line_level = !(dev_pull | switch_press);

    // ************************************************************
    // host reset input counts falling edges of the line
    // ************************************************************
    always_ff @(posedge clk)
    begin
        line_q <= line_level;
        if (line_q && !line_level)
            host_resets <= host_resets + 1;
    end
endmodule // sww_host_model

//--- bench/test_supervisor_window_watchdog.sv
`timescale 1ns/1ps
module test_supervisor_window_watchdog;
    import sww_pkg::*;
    // short tick keeps every window a few hundred cycles
    localparam int TCYC  = 20;
    localparam int LIMIT = 20_000;
    logic        clk;
    logic        nrst;
    sww_req_t    req;
    sww_rsp_t    rsp_q;
    logic        supply_low;
    logic [1:0]  trip_point_select;
    logic        pin_level;
    logic        rst_n_pin_out;
    logic        rst_n_pin_oe;
    logic        bus_lock_q;
    logic        mem_wr_busy;
    logic        mem_wr_finish_q;
    logic        press;
    int          host_resets;
    int          error_cnt;
    int          tests_run;
    int          cyc;
    int          n;
    logic [31:0] seed;
    logic [15:0] expq[$];
    logic [15:0] e;

    sww_top #(.TICK_CYC(TCYC)) dut (
        .clk(clk), .nrst(nrst), .req(req), .rsp_q(rsp_q),
        .supply_low(supply_low), .trip_point_select(trip_point_select),
        .rst_n_pin_in(pin_level), .rst_n_pin_out(rst_n_pin_out), .rst_n_pin_oe(rst_n_pin_oe),
        .bus_lock_q(bus_lock_q), .mem_wr_busy(mem_wr_busy), .mem_wr_finish_q(mem_wr_finish_q)
    );

    sww_host_model host (
        .clk(clk), .dev_pull(rst_n_pin_oe), .switch_press(press),
        .line_level(pin_level), .host_resets(host_resets)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        tests_run++;
        if (got !== ex)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        expq.push_back({a, ex});
        acc(1'b0, a, 8'h00);
    endtask

    // counts edges until oe reaches v; returns lim if it never does
    task automatic wait_oe(input logic v, input int lim, output int cnt);
        #1;
        cnt = 0;
        while (rst_n_pin_oe !== v && cnt < lim)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ************************************************************
    // clock, timeout and read answer monitor
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (rsp_q.valid === 1'b1)
        begin
            if (expq.size() == 0)
                chk("unrequested answer", 8'h00, 8'h01);
            else
            begin
                e = expq.pop_front();
                chk($sformatf("read of %h", e[15:8]), e[7:0], rsp_q.rdata);
            end
        end
        if (cyc == LIMIT)
        begin
            error_cnt++;
            $display("BAD run length expected below %0d seen %0d", LIMIT, cyc);
            close_out();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        nrst = 1'b0;
        req = '0;
        supply_low = 1'b0;
        mem_wr_busy = 1'b0;
        press = 1'b0;
        seed = 32'h12b0_c9f3;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;

        // registers: defaults, unmapped place, random readback, trip codes
        rd(8'h09, 8'h00);
        rd(8'h0C, 8'h00);
        rd(8'h33, 8'h00);
        repeat (4)
        begin
            seed = lfsr(seed);
            wr(8'h0B, seed[7:0]);
            rd(8'h0B, {3'b000, seed[4:0]});
            wr(8'h0C, seed[15:8]);
            rd(8'h0C, {seed[15], 2'b00, seed[12:8]});
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h18, {seed[23:18], i[1:0]});
            repeat (2) @(posedge clk);
            #1;
            chk("trip select", {6'h00, i[1:0]}, {6'h00, trip_point_select});
        end
        wr(8'h0B, 8'h00);
        wr(8'h0C, 8'h00);
        $display("test registers done");

        // low supply with a memory write in flight
        mem_wr_busy <= 1'b1;
        supply_low <= 1'b1;
        wait_oe(1'b1, 10, n);
        chk_rng("supply reset delay", 1, 5, n);
        chk("pin drive value", 8'h00, {7'h00, rst_n_pin_out});
        chk("bus lock", 8'h01, {7'h00, bus_lock_q});
        chk("write finish", 8'h01, {7'h00, mem_wr_finish_q});
        // a write that starts under lockout must not be finished
        @(posedge clk);
        mem_wr_busy <= 1'b0;
        @(posedge clk);
        mem_wr_busy <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("locked write finish", 8'h00, {7'h00, mem_wr_finish_q});
        acc(1'b0, 8'h09, 8'h00);
        wr(8'h0B, 8'h1F);
        supply_low <= 1'b0;
        mem_wr_busy <= 1'b0;
        wait_oe(1'b0, 300, n);
        chk_rng("supply hold", 200, 240, n);
        rd(8'h0B, 8'h00);
        rd(8'h09, 8'h20);
        wr(8'h09, 8'h00);
        rd(8'h09, 8'h00);
        $display("test supply done");

        // late fault; a wrong nibble midway must not restart
        wr(8'h0B, 8'h00);
        wr(8'h0C, 8'h81);
        wr(8'h0A, 8'h0A);
        repeat (150) @(posedge clk);
        wr(8'h0A, 8'h05);
        wait_oe(1'b1, 200, n);
        chk_rng("late fault time", 240, 250, n + 152);
        wait_oe(1'b0, 300, n);
        chk_rng("fault hold", 200, 240, n);
        wait_oe(1'b1, 300, n);
        chk_rng("restart after release", 235, 250, n);
        wait_oe(1'b0, 300, n);
        wr(8'h0C, 8'h00);
        wr(8'h0A, 8'h0A);
        rd(8'h09, 8'h40);
        wr(8'h09, 8'h00);
        $display("test late done");

        // early restart inside the open window
        wr(8'h0B, 8'h02);
        wr(8'h0C, 8'h82);
        wr(8'h0A, 8'h0A);
        repeat (20) @(posedge clk);
        wr(8'h0A, 8'h0A);
        wait_oe(1'b1, 10, n);
        chk_rng("early fault", 0, 5, n);
        wait_oe(1'b0, 300, n);
        wr(8'h0C, 8'h00);
        wr(8'h0B, 8'h00);
        wr(8'h0A, 8'h0A);
        rd(8'h09, 8'h80);
        wr(8'h09, 8'h00);
        $display("test early done");

        // disabled timer runs silently; zero close time stops it
        wr(8'h0C, 8'h01);
        wr(8'h0A, 8'h0A);
        wait_oe(1'b1, 600, n);
        chk_rng("disabled timer", 600, 600, n);
        wr(8'h0C, 8'h80);
        wr(8'h0A, 8'h0A);
        wait_oe(1'b1, 600, n);
        chk_rng("zero close time", 600, 600, n);
        rd(8'h09, 8'h00);
        $display("test quiet done");

        // manual reset held past the device hold time
        press <= 1'b1;
        wait_oe(1'b1, 8, n);
        chk_rng("manual detect", 1, 6, n);
        wait_oe(1'b0, 300, n);
        chk_rng("manual hold", 200, 240, n);
        rd(8'h09, 8'h00);
        press <= 1'b0;
        repeat (10) @(posedge clk);
        chk("host reset count", 8'd5, host_resets[7:0]);
        $display("test manual done");
        close_out();
    end
endmodule // test_supervisor_window_watchdog

//--- common/sww_pkg.sv
package sww_pkg;

    // ************************************************************
    // timebase
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 10;
    localparam int TICK_TIME_NS     = 5_000_000;
    localparam int TICK_CYCLES      = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_TIME_MS     = 5;
    localparam int HOLD_TIME_MS     = 50;
    localparam int HOLD_TICKS       = HOLD_TIME_MS / TICK_TIME_MS;
    localparam int OPEN_STEP_MS     = 25;
    localparam int CLOSE_STEP_MS    = 60;
    localparam int OPEN_STEP_TICKS  = OPEN_STEP_MS / TICK_TIME_MS;
    localparam int CLOSE_STEP_TICKS = CLOSE_STEP_MS / TICK_TIME_MS;
    localparam int TICK_CNT_W       = 24;
    localparam int WD_CNT_W         = 9;
    localparam int HOLD_CNT_W       = 4;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_FLAGS   = 8'h09;
    localparam logic [7:0] ADDR_RESTART = 8'h0A;
    localparam logic [7:0] ADDR_OPEN    = 8'h0B;
    localparam logic [7:0] ADDR_CLOSE   = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL = 8'h18;

    localparam int EARLY_BIT  = 7;
    localparam int LATE_BIT   = 6;
    localparam int POWER_BIT  = 5;
    localparam int ENABLE_BIT = 7;
    localparam int TIME_MSB   = 4;
    localparam int TRIP_MSB   = 1;

    localparam logic [3:0] RESTART_NIBBLE = 4'hA;
    localparam logic [2:0] FLAGS_RST      = 3'h0;
    localparam logic [4:0] OPEN_RST       = 5'h00;
    localparam logic [4:0] CLOSE_RST      = 5'h00;
    localparam logic       ENABLE_RST     = 1'b0;
    localparam logic [1:0] TRIP_RST       = 2'h0;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_LOW  = 2'b01,
        RS_HOLD = 2'b10,
        RS_WAIT = 2'b11
    } sww_rst_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sww_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } sww_rsp_t;

endpackage

//--- hw/sww_tick.sv
`timescale 1ns/1ps
module sww_tick #(
    parameter int TICK_CYC = sww_pkg::TICK_CYCLES
) (
    input  wire logic clk,    // system clock
    input  wire logic nrst,   // sync reset, active low
    input  wire logic clear,  // restart the tick phase
    output logic      tick_q  // one-cycle timebase pulse
);
    import sww_pkg::*;

    localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(TICK_CYC - 1);

    logic [TICK_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk)
    begin
        if (!nrst || clear)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (cnt_q == LAST)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

endmodule // sww_tick

//--- hw/sww_top.sv
// Function
// - supply below trip point drives the reset line low
// - after supply recovers, reset stays low at least 50 ms
// - serial register accesses ignored while reset is driven
// - memory write begun before lockout is allowed to finish
// - control 18h bits 1:0 select trip point 2.6/2.75/2.9/3.0 V
// - close time is field times 60 ms, up to 1.86 s
// - open time is field times 25 ms, 0 to 775 ms
// - close field at 0Ch bits 4:0, enable at 0Ch bit 7
// - writing 1010b to low nibble of 0Ah restarts the watchdog
// - valid restart loads new open and close times
// - any other nibble to 0Ah changes nothing
// - watchdog disabled while supply is below trip point
// - close field of zero stops the watchdog timer
// - enabled timeout resets; disabled timer runs without effect
// - watchdog restarts when a reset pulse is released
// - window timing counts from accepted restart command
// - external low on pin makes device drive low, at most 100 ms
// - after manual hold, commands accepted though pin held low
// - early restart sets flag bit 7, missed close sets bit 6
// - low supply sets bit 5 of 09h; manual reset sets none
// - source flags stay set until software clears them
`timescale 1ns/1ps
module sww_top
    import sww_pkg::*;
#(
    parameter int TICK_CYC = sww_pkg::TICK_CYCLES
) (
    input  wire logic      clk,               // system clock, 100 MHz
    input  wire logic      nrst,              // sync reset, active low
    input  sww_pkg::sww_req_t req,            // register access from bus decoder
    output sww_pkg::sww_rsp_t rsp_q,          // read answer
    input  wire logic      supply_low,        // comparator: supply under trip point
    output logic [1:0]     trip_point_select, // threshold code to comparator
    input  wire logic      rst_n_pin_in,      // reset pin level
    output logic           rst_n_pin_out,     // reset pin drive value
    output logic           rst_n_pin_oe,      // high while pulling pin low
    output logic           bus_lock_q,        // serial bus locked out
    input  wire logic      mem_wr_busy,       // memory write in progress
    output logic           mem_wr_finish_q    // memory write may complete
);
    import sww_pkg::*;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic reg_hit(input sww_req_t r, input logic [7:0] a);
        reg_hit = (r.addr == a);
    endfunction

    function automatic logic [WD_CNT_W-1:0] scale(input logic [4:0] v, input int step);
        scale = WD_CNT_W'(v) * WD_CNT_W'(step);
    endfunction

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [1:0] low_sync_q;
    logic [1:0] pin_sync_q;
    logic       supply_low_s;
    logic       pin_s;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            low_sync_q <= 2'b00;
            pin_sync_q <= 2'b11;
        end
        else
        begin
            low_sync_q <= {low_sync_q[0], supply_low};
            pin_sync_q <= {pin_sync_q[0], rst_n_pin_in};
        end
    end

    assign supply_low_s = low_sync_q[1];
    assign pin_s        = pin_sync_q[1];

    // ************************************************************
    // registers
    // ************************************************************
    logic [2:0]          flags_q;
    logic [4:0]          open_q;
    logic [4:0]          close_q;
    logic                enable_q;
    logic [1:0]          trip_q;
    logic                wr_ok;
    logic                restart_cmd;
    logic                bad_nibble;
    logic                tick;
    logic                wd_restart;
    logic                wd_run;
    logic                early_evt;
    logic                late_evt;
    logic [WD_CNT_W-1:0] wd_cnt_q;
    logic [WD_CNT_W-1:0] open_lim_q;
    logic [WD_CNT_W-1:0] close_lim_q;
    logic [2:0]          flag_set;
    logic [2:0]          flag_clr;
    sww_rst_state_t      state_q;
    sww_rst_state_t      state_d;
    logic                hold_done;

    assign wr_ok       = req.wr && !bus_lock_q;
    assign restart_cmd = wr_ok && reg_hit(req, ADDR_RESTART)
                         && (req.wdata[3:0] == RESTART_NIBBLE);
    assign bad_nibble  = wr_ok && reg_hit(req, ADDR_RESTART) && !restart_cmd;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            open_q   <= OPEN_RST;
            close_q  <= CLOSE_RST;
            enable_q <= ENABLE_RST;
            trip_q   <= TRIP_RST;
        end
        else if (wr_ok)
        begin
            if (reg_hit(req, ADDR_OPEN))
                open_q <= req.wdata[TIME_MSB:0];
            if (reg_hit(req, ADDR_CLOSE))
            begin
                close_q  <= req.wdata[TIME_MSB:0];
                enable_q <= req.wdata[ENABLE_BIT];
            end
            if (reg_hit(req, ADDR_CONTROL))
                trip_q <= req.wdata[TRIP_MSB:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            trip_point_select <= TRIP_RST;
        else
            trip_point_select <= trip_q;
    end

    // software clears by writing 0; a hardware set in the same cycle wins
    assign flag_set[2] = early_evt && enable_q;
    assign flag_set[1] = late_evt && enable_q;
    assign flag_set[0] = supply_low_s && (state_q != RS_LOW);
    assign flag_clr    = (wr_ok && reg_hit(req, ADDR_FLAGS))
                         ? ~req.wdata[EARLY_BIT:POWER_BIT] : 3'h0;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            flags_q <= FLAGS_RST;
        else
            flags_q <= (flags_q & ~flag_clr) | flag_set;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rsp_q <= '0;
        else
        begin
            rsp_q.valid <= req.rd && !bus_lock_q;
            rsp_q.rdata <= 8'h00;
            if (reg_hit(req, ADDR_FLAGS))
                rsp_q.rdata <= {flags_q, 5'h00};
            else if (reg_hit(req, ADDR_OPEN))
                rsp_q.rdata <= {3'h0, open_q};
            else if (reg_hit(req, ADDR_CLOSE))
                rsp_q.rdata <= {enable_q, 2'h0, close_q};
            else if (reg_hit(req, ADDR_CONTROL))
                rsp_q.rdata <= {6'h00, trip_q};
        end
    end

    // ************************************************************
    // window watchdog
    // ************************************************************
    // tick phase restarts with the window so that counts are exact times
    sww_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .clk    (clk),
        .nrst   (nrst),
        .clear  (wd_restart),
        .tick_q (tick)
    );

    assign wd_restart = restart_cmd || hold_done;
    assign wd_run     = (close_lim_q != '0) && !supply_low_s
                        && (state_q != RS_LOW) && (state_q != RS_HOLD);
    assign early_evt  = restart_cmd && wd_run && (wd_cnt_q < open_lim_q);
    assign late_evt   = wd_run && tick && ((wd_cnt_q + 1'b1) == close_lim_q);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wd_cnt_q    <= '0;
            open_lim_q  <= '0;
            close_lim_q <= '0;
        end
        else if (wd_restart)
        begin
            wd_cnt_q    <= '0;
            open_lim_q  <= scale(open_q, OPEN_STEP_TICKS);
            close_lim_q <= scale(close_q, CLOSE_STEP_TICKS);
        end
        else if (!wd_run)
            wd_cnt_q <= '0;
        else if (late_evt)
            wd_cnt_q <= '0;
        else if (tick)
            wd_cnt_q <= wd_cnt_q + 1'b1;
    end

    // ************************************************************
    // reset sequencer
    // ************************************************************
    logic [HOLD_CNT_W-1:0] hold_cnt_q;

    // one extra tick of margin: the first tick may come almost at once
    assign hold_done = (state_q == RS_HOLD) && !supply_low_s && tick
                       && (hold_cnt_q == HOLD_CNT_W'(HOLD_TICKS));

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RS_IDLE:
            begin
                if (supply_low_s)
                    state_d = RS_LOW;
                else if ((early_evt || late_evt) && enable_q)
                    state_d = RS_HOLD;
                else if (!pin_s)
                    state_d = RS_HOLD;
            end
            RS_LOW:
            begin
                if (!supply_low_s)
                    state_d = RS_HOLD;
            end
            RS_HOLD:
            begin
                if (supply_low_s)
                    state_d = RS_LOW;
                else if (hold_done)
                    state_d = RS_WAIT;
            end
            RS_WAIT:
            begin
                // pin may still be held outside; no lockout meanwhile
                if (supply_low_s)
                    state_d = RS_LOW;
                else if ((early_evt || late_evt) && enable_q)
                    state_d = RS_HOLD;
                else if (pin_s)
                    state_d = RS_IDLE;
            end
            default:
                state_d = RS_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            state_q <= RS_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst || state_q != RS_HOLD)
            hold_cnt_q <= '0;
        else if (tick)
            hold_cnt_q <= hold_cnt_q + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rst_n_pin_oe  <= 1'b0;
            rst_n_pin_out <= 1'b0;
            bus_lock_q    <= 1'b0;
        end
        else
        begin
            rst_n_pin_oe  <= (state_d == RS_LOW) || (state_d == RS_HOLD);
            rst_n_pin_out <= 1'b0;
            bus_lock_q    <= (state_d == RS_LOW) || (state_d == RS_HOLD);
        end
    end

    // ************************************************************
    // memory write completion
    // ************************************************************
    logic mem_busy_q;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mem_busy_q      <= 1'b0;
            mem_wr_finish_q <= 1'b0;
        end
        else
        begin
            mem_busy_q <= mem_wr_busy;
            if (!mem_wr_busy)
                mem_wr_finish_q <= 1'b0;
            else if (!mem_busy_q && !bus_lock_q)
                mem_wr_finish_q <= 1'b1;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    int oe_len_q;

    always_ff @(posedge clk)
    begin
        if (!nrst || !rst_n_pin_oe)
            oe_len_q <= 0;
        else
            oe_len_q <= oe_len_q + 1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_enabled_timeout;
        late_evt && enable_q && state_q == RS_IDLE;
    endsequence

    sequence s_pulled_low;
        rst_n_pin_oe && flags_q[1];
    endsequence

    a_low_drives: assert property (supply_low_s |=> rst_n_pin_oe && !rst_n_pin_out)
        else $error("supply low did not pull reset");
    a_hold_length: assert property ($fell(rst_n_pin_oe) |-> oe_len_q >= HOLD_TICKS * TICK_CYC)
        else $error("reset released before hold time");
    a_lock_reads: assert property (req.rd && bus_lock_q |=> !rsp_q.valid)
        else $error("read answered during lockout");
    a_restart_load: assert property (restart_cmd |=> wd_cnt_q == '0
        && close_lim_q == scale($past(close_q), CLOSE_STEP_TICKS))
        else $error("restart did not load window");
    a_bad_nibble: assert property (bad_nibble && !hold_done && wd_run && !tick
        |=> wd_cnt_q == $past(wd_cnt_q))
        else $error("wrong nibble disturbed watchdog");
    a_zero_stops: assert property (close_lim_q == '0 && !wd_restart |=> wd_cnt_q == '0)
        else $error("watchdog ran with zero close time");
    a_supply_stop: assert property (supply_low_s && !wd_restart |=> wd_cnt_q == '0)
        else $error("watchdog ran under low supply");
    a_late_reset: assert property (s_enabled_timeout |=> s_pulled_low)
        else $error("enabled timeout missed reset or flag");
    a_power_flag: assert property (supply_low_s |=> flags_q[0])
        else $error("power flag not set");
    a_manual_free: assert property (state_q == RS_WAIT && state_d == RS_WAIT |=> !bus_lock_q)
        else $error("lockout kept after manual hold");
    a_edge_restart: assert property (hold_done |=> wd_cnt_q == '0 ##1 !rst_n_pin_oe)
        else $error("watchdog not restarted at release");

endmodule // sww_top
